/* shared/imt_pkg.sv */
// Shared constants and types for the multi-master I2C start/transmit block
package imt_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_NS = 5;      // hclk period
  localparam int BIT_NS = 10000;  // standard mode bit period
  localparam int PH_CYC = BIT_NS / (4 * CLK_NS);
  localparam logic [15:0] PRESC_RST = 16'(PH_CYC);
  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFF_CTRL  = 8'h00;
  localparam logic [7:0] OFF_ADDR  = 8'h04;
  localparam logic [7:0] OFF_TRANSMIT_BUFFER = 8'h08;
  localparam logic [7:0] OFF_STAT  = 8'h0c;
  localparam logic [7:0] OFF_IST   = 8'h10;
  localparam logic [7:0] OFF_ICLR  = 8'h14;
  localparam logic [7:0] OFF_IEN   = 8'h18;
  localparam logic [7:0] OFF_PRESC = 8'h1c;
  // ==========================================================
  // Field positions and reset values
  localparam int CB_MM  = 0;
  localparam int CB_TR  = 1;
  localparam int CB_STT = 2;
  localparam int CB_STP = 3;
  localparam int CB_EN  = 4;
  localparam int NCTL   = 5;
  localparam int IB_TXE = 0;
  localparam int IB_STT = 1;
  localparam int IB_STP = 2;
  localparam int IB_NAK = 3;
  localparam int NIRQ   = 4;
  localparam logic [NCTL-1:0] CTRL_RST = 5'h00;
  localparam logic [6:0]      ADDR_RST = 7'h00;
  localparam logic [NIRQ-1:0] IEN_RST  = 4'h0;
  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_WAIT  = 3'b001,
    ST_START = 3'b010,
    ST_BIT   = 3'b011,
    ST_ACK   = 3'b100,
    ST_HOLD  = 3'b101,
    ST_STOP  = 3'b110
  } imt_state_t;
  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } imt_req_t;
endpackage

/* rtl/imt_sync.sv */
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module imt_sync import imt_pkg::*; #(
  parameter int W = 2
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] m_q;
  // A zero-width bus leaves nothing to synchronise
  if (W < 1) begin : g_bad_w
    $error("imt_sync needs W of at least 1");
  end
  // ==========================================================
  // One pair of flops per bit; the first flop feeds only the second
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        m_q[i] <= 1'b1;
        q[i]   <= 1'b1;
      end else begin
        m_q[i] <= d[i];
        q[i]   <= m_q[i];
      end
    end
  end
endmodule

/* rtl/imt_ahb.sv */
// AHB-Lite slave front end: turns bus transfers into register requests
`timescale 1ns/1ps
module imt_ahb import imt_pkg::*; (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output imt_req_t         req
);
  logic       wr_q;
  logic [7:0] addr_q;
  logic       take;
  // Zero wait states; every transfer answers OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign take      = hsel & htrans[1] & hready;
  // ==========================================================
  // Address phase capture; only word transfers are writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q   <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      wr_q <= take & hwrite & (hsize == 3'h2);
      if (take) begin
        addr_q <= haddr[7:0];
      end
    end
  end
  // Write strobe lives in the data phase, with hwdata
  assign req = '{wr: wr_q, addr: addr_q, wdata: hwdata};
endmodule

/* rtl/imt_core.sv */
// Multi-master I2C transmitter with bus-wait start and self-clearing flags
// Functional notes
// - Start on busy bus in multi-master transmit: wait idle until bus free.
// - Transmit buffer writes during bus wait are dropped, never shifted.
// - In bus wait, empty flag may rise on foreign clock activity.
// - Start, stop and no-ack flags are also cleared by bus events.
// - Interrupt pends when a flag and its enable are both 1.
`timescale 1ns/1ps
module imt_core import imt_pkg::*; (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  output logic             irq
);
  imt_req_t        req;
  imt_state_t      state_q;
  logic [NCTL-1:0] ctl_q;
  logic [6:0]      addr_q;
  logic [7:0]      transmit_buffer_q;
  logic            txv_q;
  logic [15:0]     presc_q;
  logic [15:0]     cnt_q;
  logic [NIRQ-1:0] ist_q;
  logic [NIRQ-1:0] ien_q;
  logic [NIRQ-1:0] ev;
  logic [NIRQ-1:0] hw_clr;
  logic [NIRQ-1:0] sw_clr;
  logic [1:0]      ph_q;
  logic [2:0]      bitn_q;
  logic [7:0]      sh_q;
  logic            scl_drv_q, sda_drv_q, busy_q;
  logic            scl_s, sda_s, scl_p_q, sda_p_q;
  logic            start_det, stop_det, scl_fall;
  logic            tick, adv, go;
  logic            tx_wr, consume;
  logic            hw_stt_clr, hw_stp_clr;

  imt_ahb u_ahb (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .req       (req)
  );
  imt_sync #(.W(2)) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       ({scl_i, sda_i}),
    .q       ({scl_s, sda_s})
  );
  // ==========================================================
  // Bus monitor
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end
  assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_det  = scl_s & scl_p_q & ~sda_p_q & sda_s;
  assign scl_fall  = scl_p_q & ~scl_s;
  // Occupied from any start until the next stop, ours included
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_q <= 1'b0;
    end else if (start_det) begin
      busy_q <= 1'b1;
    end else if (stop_det) begin
      busy_q <= 1'b0;
    end
  end
  // ==========================================================
  // Quarter-bit tick; a target stretching SCL freezes the sequence
  assign tick = (cnt_q == 16'h0000);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= PRESC_RST;
    end else if (tick) begin
      cnt_q <= presc_q;
    end else begin
      cnt_q <= cnt_q - 16'h0001;
    end
  end
  assign adv = tick & ~(~scl_drv_q & ~scl_s);
  assign go  = ctl_q[CB_EN] & ctl_q[CB_TR] & ctl_q[CB_STT];
  assign consume = adv & (((state_q == ST_ACK) & (ph_q == 2'h3) & ~sda_s) |
                   (state_q == ST_HOLD)) & txv_q;
  // ==========================================================
  // Master sequence
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q   <= ST_IDLE;
      ph_q      <= 2'h0;
      bitn_q    <= 3'h0;
      sh_q      <= 8'h00;
      scl_drv_q <= 1'b0;
      sda_drv_q <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          scl_drv_q <= 1'b0;
          sda_drv_q <= 1'b0;
          ph_q      <= 2'h0;
          if (go) begin
            // Never cut into someone else's frame
            state_q <= busy_q ? ST_WAIT : ST_START;
          end
        end
        ST_WAIT: begin
          // Pins stay released while the other masters finish
          if (!busy_q) begin
            state_q <= ST_START;
          end else if (!go) begin
            state_q <= ST_IDLE;
          end
        end
        ST_START: if (adv) begin
          ph_q <= ph_q + 2'h1;
          if (ph_q == 2'h0) begin
            sda_drv_q <= 1'b1;
          end else if (ph_q == 2'h1) begin
            scl_drv_q <= 1'b1;
            sh_q      <= {addr_q, 1'b0};
            bitn_q    <= 3'h0;
            ph_q      <= 2'h0;
            state_q   <= ST_BIT;
          end
        end
        ST_BIT: if (adv) begin
          ph_q <= ph_q + 2'h1;
          unique case (ph_q)
            2'h0: sda_drv_q <= ~sh_q[7];
            2'h1: scl_drv_q <= 1'b0;
            2'h2: scl_drv_q <= 1'b0;
            2'h3: begin
              scl_drv_q <= 1'b1;
              sh_q      <= {sh_q[6:0], 1'b0};
              bitn_q    <= bitn_q + 3'h1;
              if (bitn_q == 3'h7) begin
                state_q <= ST_ACK;
              end
            end
          endcase
        end
        ST_ACK: if (adv) begin
          ph_q <= ph_q + 2'h1;
          unique case (ph_q)
            2'h0: sda_drv_q <= 1'b0;
            2'h1: scl_drv_q <= 1'b0;
            2'h2: scl_drv_q <= 1'b0;
            2'h3: begin
              scl_drv_q <= 1'b1;
              if (sda_s) begin
                state_q <= ST_STOP;
              end else if (txv_q) begin
                sh_q    <= transmit_buffer_q;
                state_q <= ST_BIT;
              end else if (ctl_q[CB_STP]) begin
                state_q <= ST_STOP;
              end else begin
                state_q <= ST_HOLD;
              end
            end
          endcase
        end
        ST_HOLD: if (adv) begin
          // SCL held low until software supplies data or a stop
          if (txv_q) begin
            sh_q    <= transmit_buffer_q;
            ph_q    <= 2'h0;
            state_q <= ST_BIT;
          end else if (ctl_q[CB_STP]) begin
            ph_q    <= 2'h0;
            state_q <= ST_STOP;
          end
        end
        ST_STOP: if (adv) begin
          ph_q <= ph_q + 2'h1;
          unique case (ph_q)
            2'h0: sda_drv_q <= 1'b1;
            2'h1: scl_drv_q <= 1'b0;
            2'h2: sda_drv_q <= 1'b0;
            2'h3: state_q   <= ST_IDLE;
          endcase
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
  assign scl_o  = 1'b0;
  assign sda_o  = 1'b0;
  assign scl_oe = scl_drv_q;
  assign sda_oe = sda_drv_q;
  // ==========================================================
  // Control registers; hardware clears start/stop requests, a write wins
  assign hw_stt_clr = (state_q == ST_START) & adv & (ph_q == 2'h1);
  assign hw_stp_clr = (state_q == ST_STOP) & adv & (ph_q == 2'h3);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl_q   <= CTRL_RST;
      addr_q  <= ADDR_RST;
      ien_q   <= IEN_RST;
      presc_q <= PRESC_RST;
    end else begin
      if (hw_stt_clr) begin
        ctl_q[CB_STT] <= 1'b0;
      end
      if (hw_stp_clr) begin
        ctl_q[CB_STP] <= 1'b0;
      end
      if (req.wr) begin
        unique case (req.addr)
          OFF_CTRL:  ctl_q   <= req.wdata[NCTL-1:0];
          OFF_ADDR:  addr_q  <= req.wdata[6:0];
          OFF_IEN:   ien_q   <= req.wdata[NIRQ-1:0];
          OFF_PRESC: presc_q <= req.wdata[15:0];
          default:   ;
        endcase
      end
    end
  end

  // Buffer writes during bus wait are dropped: the start is not out yet
  assign tx_wr = req.wr & (req.addr == OFF_TRANSMIT_BUFFER) & (state_q != ST_WAIT);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txv_q   <= 1'b0;
      transmit_buffer_q <= 8'h00;
    end else if (tx_wr) begin
      txv_q   <= 1'b1;
      transmit_buffer_q <= req.wdata[7:0];
    end else if (consume || (state_q == ST_IDLE)) begin
      txv_q <= 1'b0;
    end
  end

  // ==========================================================
  // Event flags; a set in the clearing cycle survives
  always_comb begin
    ev         = '0;
    ev[IB_TXE] = consume | hw_stt_clr |
                 ((state_q == ST_WAIT) & scl_fall);
    ev[IB_STT] = start_det;
    ev[IB_STP] = stop_det;
    ev[IB_NAK] = adv & (state_q == ST_ACK) & (ph_q == 2'h3) & sda_s;
    hw_clr         = '0;
    hw_clr[IB_TXE] = tx_wr;
    hw_clr[IB_STT] = stop_det;
    hw_clr[IB_STP] = start_det;
    hw_clr[IB_NAK] = start_det;
    sw_clr = (req.wr && req.addr == OFF_ICLR) ? req.wdata[NIRQ-1:0] : '0;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ist_q <= '0;
    end else begin
      ist_q <= (ist_q & ~hw_clr & ~sw_clr) | ev;
    end
  end
  // No global gate here: the level follows flag and enable only
  assign irq = |(ist_q & ien_q);

  // ==========================================================
  // Read data for the current data phase
  always_comb begin
    unique case (req.addr)
      OFF_CTRL:  hrdata = {27'h0, ctl_q};
      OFF_ADDR:  hrdata = {25'h0, addr_q};
      OFF_TRANSMIT_BUFFER: hrdata = {24'h0, transmit_buffer_q};
      OFF_STAT:  hrdata = {27'h0, txv_q, state_q, busy_q};
      OFF_IST:   hrdata = {28'h0, ist_q};
      OFF_IEN:   hrdata = {28'h0, ien_q};
      OFF_PRESC: hrdata = {16'h0, presc_q};
      default:   hrdata = 32'h0000_0000;
    endcase
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_stop_end;
    state_q == ST_STOP && ph_q == 2'h3 && adv;
  endsequence
  sequence s_busy_go;
    state_q == ST_IDLE && go && busy_q;
  endsequence
  AST_WAIT_ENTRY: assert property (s_busy_go |=> state_q == ST_WAIT)
    else $error("busy start did not wait");
  AST_WAIT_QUIET: assert property (state_q == ST_WAIT |-> !scl_oe && !sda_oe)
    else $error("pins driven while waiting");
  AST_TX_DROP: assert property (
    state_q == ST_WAIT && req.wr && req.addr == OFF_TRANSMIT_BUFFER && !txv_q |=> !txv_q)
    else $error("buffer write kept during wait");
  AST_TXE_WAIT: assert property (
    state_q == ST_WAIT && scl_fall |=> ist_q[IB_TXE])
    else $error("empty flag not raised in wait");
  AST_STT_HWCLR: assert property (
    stop_det && !start_det |=> !ist_q[IB_STT])
    else $error("start flag survived a stop");
  AST_NAK_HWCLR: assert property (
    start_det && !ev[IB_NAK] |=> !ist_q[IB_NAK] && !ist_q[IB_STP])
    else $error("flags survived a start");
  AST_IRQ_PEND: assert property (
    $rose(ist_q[IB_NAK]) && $past(ien_q[IB_NAK]) && ien_q[IB_NAK] |-> irq)
    else $error("enabled flag gave no interrupt");
  AST_STOP_DONE: assert property (
    s_stop_end |=> state_q == ST_IDLE && !scl_oe && !sda_oe && !ctl_q[CB_STP])
    else $error("stop did not release bus");
endmodule

/* tb/imt_bus_agent.sv */
// Far side model: a foreign master making frames and a slave that acks bytes
`timescale 1ns/1ps
module imt_bus_agent (
  input  wire logic       scl_oe,
  input  wire logic       sda_oe,
  input  wire logic       ack_en,
  output wire logic       scl,
  output wire logic       sda,
  output logic      [7:0] last_byte,
  output int              n_bytes
);
  logic       f_scl_low = 1'b0;
  logic       f_sda_low = 1'b0;
  logic       a_sda_low = 1'b0;
  logic       act       = 1'b0;
  logic [7:0] sh        = 8'h00;
  int         nb        = 0;
  // ==========================================================
  // Wired-AND lines with pull-ups: a released line always reads high
  assign scl = ~(scl_oe | f_scl_low);
  assign sda = ~(sda_oe | f_sda_low | a_sda_low);
  initial begin
    last_byte = 8'h00;
    n_bytes   = 0;
  end
  // ==========================================================
  // Slave side: frame detection, MSB first capture, ack on ninth clock
  always @(negedge sda) begin
    if (scl) begin
      act = 1'b1;
      nb  = 0;
    end
  end
  always @(posedge sda) begin
    if (scl) begin
      act = 1'b0;
    end
  end
  always @(posedge scl) begin
    if (act && nb >= 1 && nb <= 8) begin
      sh = {sh[6:0], sda};
    end
  end
  // Ack only changes while SCL is low, so it never fakes a start or stop
  always @(negedge scl) begin
    if (act) begin
      nb = nb + 1;
      if (nb == 9) begin
        last_byte = sh;
        n_bytes   = n_bytes + 1;
        a_sda_low = ack_en;
      end else if (nb == 10) begin
        a_sda_low = 1'b0;
        nb        = 1;
      end
    end
  end
  // ==========================================================
  // Foreign master: link clock of 80 ns, still between frames
  task automatic f_start();
    f_sda_low = 1'b1;
    #40 f_scl_low = 1'b1;
  endtask
  task automatic f_clk(input int n);
    repeat (n) begin
      #40 f_scl_low = 1'b0;
      #40 f_scl_low = 1'b1;
    end
  endtask
  task automatic f_stop();
    #40 f_scl_low = 1'b0;
    #40 f_sda_low = 1'b0;
    #40;
  endtask
endmodule

/* tb/imt_tb.sv */
// Self-checking bench for the multi-master start/transmit block
`timescale 1ns/1ps
module testbench import imt_pkg::*; ;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic        hwrite;
  logic        ack_en;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  wire logic   hready;
  wire logic   hresp;
  wire logic   scl_o;
  wire logic   sda_o;
  wire logic   scl_oe;
  wire logic   sda_oe;
  wire logic   irq;
  wire logic   scl;
  wire logic   sda;
  wire logic [31:0] hrdata;
  wire logic [7:0]  last_byte;
  int          n_bytes;
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          cyc = 0;
  logic [31:0] r;

  imt_core dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(hresp), .hrdata(hrdata), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));
  imt_bus_agent ag (.scl_oe(scl_oe), .sda_oe(sda_oe), .ack_en(ack_en), .scl(scl), .sda(sda),
    .last_byte(last_byte), .n_bytes(n_bytes));

  // ==========================================================
  // Clock, and a cycle ceiling well above the fewer than two thousand cycles needed
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      results();
    end
  end

  task automatic results();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask

  // ==========================================================
  // AHB-Lite single word transfer; read data taken at the data phase edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h000000, a};
    hwrite <= w;
    hsize  <= 3'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h00000000, q);
  endtask
  // Polls a field under a bounded count of reads, then judges it
  task automatic poll(input string nm, input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] v);
    logic [31:0] q;
    int          k;
    k = 0;
    do begin
      rd(a, q);
      k++;
    end while (((q & m) !== v) && k < 2000);
    chk(nm, v, q & m);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    rd(OFF_CTRL, r);
    chk("ctrl reset", 32'h00000000, r);
    rd(OFF_IEN, r);
    chk("irq enable reset", 32'h00000000, r);
    rd(OFF_PRESC, r);
    chk("divider reset", 32'h000001f4, r);
    wr(8'h20, 32'hffffffff);
    rd(8'h20, r);
    chk("unmapped", 32'h00000000, r);
    chk("irq idle", 32'h0, {31'h0, irq});
    chk("bus response", 32'h0, {31'h0, hresp});
    chk("pin levels", 32'h0, {30'h0, scl_o, sda_o});
  endtask

  // Start asked on a busy bus, data loaded too early, then a clean frame
  task automatic t_wait_start();
    // Fast bit rate is allowed here: no repeated start is ever made
    wr(OFF_PRESC, 32'h00000007);
    wr(OFF_ADDR, 32'h0000002a);
    ag.f_start();
    repeat (10) @(posedge hclk);
    rd(OFF_STAT, r);
    chk("bus occupied", 32'h1, r & 32'h1);
    wr(OFF_CTRL, 32'h00000017);
    rd(OFF_STAT, r);
    chk("wait state", 32'h2, r & 32'he);
    chk("quiet pins", 32'h0, {30'h0, scl_oe, sda_oe});
    ag.f_clk(4);
    repeat (10) @(posedge hclk);
    rd(OFF_IST, r);
    chk("empty flag in wait", 32'h1, r & 32'h1);
    wr(OFF_TRANSMIT_BUFFER, 32'h000000a5);
    ag.f_stop();
    poll("start taken", OFF_CTRL, 32'h4, 32'h0);
    poll("hold after address", OFF_STAT, 32'he, 32'ha);
    chk("address byte", 32'h54, {24'h0, last_byte});
    chk("bytes sent", 32'd1, n_bytes);
    wr(OFF_TRANSMIT_BUFFER, 32'h0000003c);
    wr(OFF_CTRL, 32'h0000001b);
    poll("back to idle", OFF_STAT, 32'he, 32'h0);
    chk("data byte", 32'h3c, {24'h0, last_byte});
    chk("bytes total", 32'd2, n_bytes);
    rd(OFF_CTRL, r);
    chk("stop request cleared", 32'h0, r & 32'h8);
    chk("lines released", 32'h3, {30'h0, scl, sda});
  endtask

  // Event flags cleared by bus events, and the level output against enables
  task automatic t_flags();
    wr(OFF_IEN, 32'h0000000e);
    wr(OFF_ICLR, 32'h0000000f);
    rd(OFF_IST, r);
    chk("flags cleared", 32'h0, r & 32'he);
    chk("irq after clear", 32'h0, {31'h0, irq});
    ag.f_start();
    repeat (10) @(posedge hclk);
    rd(OFF_IST, r);
    chk("start seen", 32'h2, r & 32'he);
    chk("irq pending", 32'h1, {31'h0, irq});
    wr(OFF_IEN, 32'h00000000);
    @(posedge hclk);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(OFF_IEN, 32'h00000002);
    ag.f_clk(2);
    ag.f_stop();
    repeat (10) @(posedge hclk);
    rd(OFF_IST, r);
    chk("stop clears start", 32'h4, r & 32'he);
    chk("stop not enabled", 32'h0, {31'h0, irq});
    ag.f_start();
    repeat (10) @(posedge hclk);
    rd(OFF_IST, r);
    chk("start clears stop", 32'h2, r & 32'he);
    ag.f_stop();
    wr(OFF_IEN, 32'h00000000);
  endtask

  // Address refused by the slave: no-ack flag, stop, and a later start clears it
  task automatic t_nack();
    ack_en <= 1'b0;
    wr(OFF_IEN, 32'h00000008);
    wr(OFF_ICLR, 32'h0000000f);
    rd(OFF_STAT, r);
    chk("bus free before start", 32'h0, r & 32'h1);
    wr(OFF_CTRL, 32'h00000017);
    poll("start taken", OFF_CTRL, 32'h4, 32'h0);
    poll("idle after nack", OFF_STAT, 32'he, 32'h0);
    rd(OFF_IST, r);
    chk("no ack flag", 32'h8, r & 32'h8);
    chk("no ack irq", 32'h1, {31'h0, irq});
    chk("nack byte", 32'h54, {24'h0, last_byte});
    ack_en <= 1'b1;
    ag.f_start();
    repeat (10) @(posedge hclk);
    rd(OFF_IST, r);
    chk("start clears no ack", 32'h0, r & 32'h8);
    chk("irq after start", 32'h0, {31'h0, irq});
    ag.f_stop();
  endtask

  // ==========================================================
  // Main sequence: every input set at time zero, reset for 8 cycles
  initial begin
    hresetn = 1'b0;
    hsel    = 1'b0;
    htrans  = 2'h0;
    haddr   = 32'h00000000;
    hwrite  = 1'b0;
    hsize   = 3'h2;
    hwdata  = 32'h00000000;
    ack_en  = 1'b1;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_wait_start();
    t_flags();
    t_nack();
    results();
  end
endmodule
